// ---- verilog/timer8_regs.vh ----
// Register offsets, field positions, reset values and timing counts
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH

// Register indices on the plain register port
`define ADDR_TIMER_CONTROL   3'h0
`define ADDR_COUNTER_VALUE   3'h1
`define ADDR_COMPARE_VALUE_A 3'h2
`define ADDR_INTERRUPT_MASK  3'h3
`define ADDR_INTERRUPT_FLAGS 3'h4
`define ADDR_IRQ_STATUS      3'h5
`define ADDR_IRQ_CLEAR       3'h6
`define ADDR_IRQ_ENABLE      3'h7

// timer_control fields
`define FORCE_BIT      7
`define WGM_LO_BIT     6
`define COM_HI_BIT     5
`define COM_LO_BIT     4
`define WGM_HI_BIT     3
`define CS_HI_BIT      2
`define CS_LO_BIT      0

// Flag bit positions
`define OVF_BIT        0
`define CMP_BIT        1

// Waveform modes
`define MODE_NORMAL    2'h0
`define MODE_PC_PWM    2'h1
`define MODE_CTC       2'h2
`define MODE_FAST_PWM  2'h3

// Clock select codes
`define CS_STOP        3'h0
`define CS_DIV1        3'h1
`define CS_DIV8        3'h2
`define CS_DIV64       3'h3
`define CS_DIV256      3'h4
`define CS_DIV1024     3'h5
`define CS_EXT_FALL    3'h6
`define CS_EXT_RISE    3'h7

// Counter limits and reset values
`define CNT_MAX        8'hFF
`define CNT_BOTTOM     8'h00
`define RESET_BYTE     8'h00

// Prescaler tap match values, one less than each divisor
`define DIV_TAP8       3'h7
`define DIV_TAP64      6'h3F
`define DIV_TAP256     8'hFF
`define DIV_TAP1024    10'h3FF

`endif

// ---- verilog/timer8_waveform_unit.v ----
// 8-bit timer/counter with one compare channel and waveform output
//
// Functional notes
// - Mode field picks normal, phase-correct, clear-on-match or fast PWM.
// - Nonzero compare output mode hands the pin to the waveform output.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clear on match set at top; 11 inverse.
// - Phase-correct: 10 clear matching up, set matching down; 11 inverse.
// - PWM with compare equal top and upper bit: match ignored, top acts.
// - Clock select: stop, undivided, or prescaler taps 8/64/256/1024.
// - Codes 110 and 111 count external pin falling or rising edges.
// - External edges count even while that pin is an output.
// - Counter register is directly readable and writable.
// - Counter write suppresses a compare match on the next timer tick.
// - Compare register checked against counter each tick; match feeds flag, wave.
// - Compare flag bit 1 sets on every counter match.
// - Overflow flag bit 0 sets at overflow, or at bottom reversal in phase PWM.
// - Flags clear on vector taken or writing one; zero does nothing.
// - Request only when mask, flag and global enable are all set.
// - Force strobe acts on output in non-PWM only, no flag, no clear, reads 0.
`include "timer8_regs.vh"
`default_nettype none

module timer8_waveform_unit #(
  parameter DATA_W = 8
) (
  // Clock and reset
  input  wire              mclk,
  input  wire              rst_b,
  // Register port
  input  wire [2:0]        reg_addr,
  input  wire [DATA_W-1:0] reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [DATA_W-1:0] reg_rdata_q,
  // CPU interrupt side
  input  wire              global_irq_en,
  input  wire              cmp_vector_taken,
  input  wire              ovf_vector_taken,
  output reg               cmp_irq_req_q,
  output reg               ovf_irq_req_q,
  output reg               irq_q,
  // Pins
  input  wire              ext_count_pin,
  input  wire              port_dir_out,
  input  wire              port_data,
  output reg               compare_out_pin_q,
  output reg               compare_out_oe_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [1:0]        waveform_mode_bits_q;
  reg [1:0]        compare_output_mode_q;
  reg [2:0]        clock_source_select_q;
  reg [DATA_W-1:0] counter_value_q;
  reg [DATA_W-1:0] compare_value_a_q;
  reg [DATA_W-1:0] compare_buf_q;
  reg [1:0]        interrupt_mask_q;
  reg [1:0]        interrupt_flags_q;
  reg [1:0]        irq_status_q;
  reg [1:0]        irq_enable_q;
  reg              count_down_q;
  reg              wave_q;
  reg              block_match_q;
  reg [9:0]        presc_q;
  reg              ext_s1_q;
  reg              ext_s2_q;
  reg              ext_s3_q;

  wire wr_ctrl  = reg_wr && (reg_addr == `ADDR_TIMER_CONTROL);
  wire wr_cnt   = reg_wr && (reg_addr == `ADDR_COUNTER_VALUE);
  wire wr_cmp   = reg_wr && (reg_addr == `ADDR_COMPARE_VALUE_A);
  wire wr_mask  = reg_wr && (reg_addr == `ADDR_INTERRUPT_MASK);
  wire wr_flags = reg_wr && (reg_addr == `ADDR_INTERRUPT_FLAGS);
  wire wr_iclr  = reg_wr && (reg_addr == `ADDR_IRQ_CLEAR);
  wire wr_ien   = reg_wr && (reg_addr == `ADDR_IRQ_ENABLE);

  wire pwm_mode = (waveform_mode_bits_q == `MODE_FAST_PWM) ||
                  (waveform_mode_bits_q == `MODE_PC_PWM);

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and count source
  // Free running; first count after enabling lands 1 to N cycles later
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      presc_q <= 10'h000;
    end else begin
      presc_q <= presc_q + 10'h001;
    end
  end

  // Two flops before the edge detector; third holds previous level
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_count_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  reg tick;
  always @* begin
    case (clock_source_select_q)
      `CS_STOP:     tick = 1'b0;
      `CS_DIV1:     tick = 1'b1;
      `CS_DIV8:     tick = (presc_q[2:0] == `DIV_TAP8);
      `CS_DIV64:    tick = (presc_q[5:0] == `DIV_TAP64);
      `CS_DIV256:   tick = (presc_q[7:0] == `DIV_TAP256);
      `CS_DIV1024:  tick = (presc_q == `DIV_TAP1024);
      `CS_EXT_FALL: tick = ext_s3_q && !ext_s2_q;
      default:      tick = !ext_s3_q && ext_s2_q;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, top and compare
  wire [DATA_W-1:0] top_val =
    (waveform_mode_bits_q == `MODE_CTC) ? compare_value_a_q : `CNT_MAX;
  // Double-buffered in PWM modes, immediate otherwise
  wire [DATA_W-1:0] cmp_eff = pwm_mode ? compare_buf_q : compare_value_a_q;
  wire at_top    = (counter_value_q == top_val);
  wire at_bottom = (counter_value_q == `CNT_BOTTOM);
  wire raw_match = tick && !block_match_q &&
                   (counter_value_q == cmp_eff);
  // In PWM modes the waveform ignores a match at top with upper mode bit set
  wire wave_match = raw_match && !(pwm_mode && compare_output_mode_q[1] &&
                    (cmp_eff == `CNT_MAX));
  wire pc_mode  = (waveform_mode_bits_q == `MODE_PC_PWM);
  wire ovf_evt  = tick && (pc_mode ? (at_bottom && count_down_q)
                                   : (counter_value_q == `CNT_MAX));
  wire pc_turn_top = pc_mode && at_top && !count_down_q;
  wire pc_turn_bot = pc_mode && at_bottom && count_down_q;
  wire update_at_top = tick && pwm_mode &&
                       (pc_mode ? pc_turn_top : at_top);

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      counter_value_q <= `RESET_BYTE;
      count_down_q    <= 1'b0;
      block_match_q   <= 1'b0;
      compare_buf_q   <= `RESET_BYTE;
    end else begin
      if (update_at_top || !pwm_mode) begin
        compare_buf_q <= compare_value_a_q;
      end
      if (wr_cnt) begin
        counter_value_q <= reg_wdata;
        block_match_q   <= 1'b1;
      end else if (tick) begin
        block_match_q <= 1'b0;
        if (pc_mode) begin
          if (pc_turn_top) begin
            count_down_q    <= 1'b1;
            counter_value_q <= counter_value_q - 8'h01;
          end else if (pc_turn_bot) begin
            count_down_q    <= 1'b0;
            counter_value_q <= counter_value_q + 8'h01;
          end else if (count_down_q) begin
            counter_value_q <= counter_value_q - 8'h01;
          end else begin
            counter_value_q <= counter_value_q + 8'h01;
          end
        end else if (at_top) begin
          counter_value_q <= `CNT_BOTTOM;
          count_down_q    <= 1'b0;
        end else begin
          counter_value_q <= counter_value_q + 8'h01;
          count_down_q    <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform generator
  // Force acts on the mode bits written with it, not the old ones
  wire force_cmp = wr_ctrl && reg_wdata[`FORCE_BIT] &&
                   !reg_wdata[`WGM_LO_BIT];
  wire [1:0] force_com = reg_wdata[`COM_HI_BIT:`COM_LO_BIT];
  reg  wave_d;
  always @* begin
    wave_d = wave_q;
    case (waveform_mode_bits_q)
      `MODE_NORMAL, `MODE_CTC: begin
        if (wave_match) begin
          case (compare_output_mode_q)
            2'h1:    wave_d = !wave_q;
            2'h2:    wave_d = 1'b0;
            2'h3:    wave_d = 1'b1;
            default: wave_d = wave_q;
          endcase
        end
      end
      `MODE_FAST_PWM: begin
        if (compare_output_mode_q[1]) begin
          if (tick && at_top) begin
            wave_d = !compare_output_mode_q[0];
          end else if (wave_match) begin
            wave_d = compare_output_mode_q[0];
          end
        end
      end
      default: begin
        if (compare_output_mode_q[1]) begin
          if (tick && pc_turn_top && compare_buf_q == `CNT_MAX) begin
            wave_d = !compare_output_mode_q[0];
          end else if (wave_match) begin
            wave_d = count_down_q ? !compare_output_mode_q[0]
                                  : compare_output_mode_q[0];
          end
        end
      end
    endcase
    if (force_cmp) begin
      case (force_com)
        2'h1:    wave_d = !wave_q;
        2'h2:    wave_d = 1'b0;
        2'h3:    wave_d = 1'b1;
        default: wave_d = wave_q;
      endcase
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wave_q            <= 1'b0;
      compare_out_pin_q <= 1'b0;
      compare_out_oe_q  <= 1'b0;
    end else begin
      wave_q            <= wave_d;
      compare_out_pin_q <= (compare_output_mode_q != 2'h0) ? wave_d
                                                           : port_data;
      compare_out_oe_q  <= port_dir_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      waveform_mode_bits_q  <= `MODE_NORMAL;
      compare_output_mode_q <= 2'h0;
      clock_source_select_q <= `CS_STOP;
      compare_value_a_q     <= `RESET_BYTE;
      interrupt_mask_q      <= 2'h0;
      irq_enable_q          <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        waveform_mode_bits_q  <= {reg_wdata[`WGM_HI_BIT],
                                  reg_wdata[`WGM_LO_BIT]};
        compare_output_mode_q <= reg_wdata[`COM_HI_BIT:`COM_LO_BIT];
        clock_source_select_q <= reg_wdata[`CS_HI_BIT:`CS_LO_BIT];
      end
      if (wr_cmp) begin
        compare_value_a_q <= reg_wdata;
      end
      if (wr_mask) begin
        interrupt_mask_q <= reg_wdata[1:0];
      end
      if (wr_ien) begin
        irq_enable_q <= reg_wdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupts; a set in the same cycle as a clear wins
  wire [1:0] evt = {raw_match, ovf_evt};
  wire [1:0] taken = {cmp_vector_taken, ovf_vector_taken};
  wire [1:0] flag_clr = (wr_flags ? reg_wdata[1:0] : 2'h0) | taken;
  wire [1:0] stat_clr = wr_iclr ? reg_wdata[1:0] : 2'h0;
  wire [1:0] flags_d  = evt | (interrupt_flags_q & ~flag_clr);
  wire [1:0] stat_d   = evt | (irq_status_q & ~stat_clr);

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_flags_q <= 2'h0;
      irq_status_q      <= 2'h0;
      cmp_irq_req_q     <= 1'b0;
      ovf_irq_req_q     <= 1'b0;
      irq_q             <= 1'b0;
    end else begin
      interrupt_flags_q <= flags_d;
      irq_status_q      <= stat_d;
      cmp_irq_req_q     <= global_irq_en && interrupt_mask_q[`CMP_BIT] &&
                           flags_d[`CMP_BIT];
      ovf_irq_req_q     <= global_irq_en && interrupt_mask_q[`OVF_BIT] &&
                           flags_d[`OVF_BIT];
      irq_q             <= |(stat_d & irq_enable_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= `RESET_BYTE;
    end else if (reg_rd) begin
      if (reg_addr == `ADDR_TIMER_CONTROL) begin
        // Force strobe position always reads zero
        reg_rdata_q <= {1'b0, waveform_mode_bits_q[0], compare_output_mode_q,
                        waveform_mode_bits_q[1], clock_source_select_q};
      end else if (reg_addr == `ADDR_COUNTER_VALUE) begin
        reg_rdata_q <= counter_value_q;
      end else if (reg_addr == `ADDR_COMPARE_VALUE_A) begin
        reg_rdata_q <= compare_value_a_q;
      end else if (reg_addr == `ADDR_INTERRUPT_MASK) begin
        reg_rdata_q <= {6'h00, interrupt_mask_q};
      end else if (reg_addr == `ADDR_INTERRUPT_FLAGS) begin
        reg_rdata_q <= {6'h00, interrupt_flags_q};
      end else if (reg_addr == `ADDR_IRQ_STATUS) begin
        reg_rdata_q <= {6'h00, irq_status_q};
      end else if (reg_addr == `ADDR_IRQ_ENABLE) begin
        reg_rdata_q <= {6'h00, irq_enable_q};
      end else begin
        reg_rdata_q <= `RESET_BYTE;
      end
    end else begin
      reg_rdata_q <= `RESET_BYTE;
    end
  end

endmodule // timer8_waveform_unit

`default_nettype wire

// ---- sim/timer8_waveform_unit_assertions.sv ----
// Checker for the timer register port, interrupt and pin outputs
`default_nettype none
module timer8_waveform_unit_assertions (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // Interrupts and pins
  input wire logic       global_irq_en,
  input wire logic       cmp_irq_req_q,
  input wire logic       ovf_irq_req_q,
  input wire logic       port_dir_out,
  input wire logic       compare_out_oe_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence rd_at(logic [2:0] a);
    reg_rd && reg_addr == a;
  endsequence
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata_q == 8'h00)
    else $error("read data not idle");
  AST_FORCE_RD0: assert property (rd_at(3'h0) |=> !reg_rdata_q[7])
    else $error("force strobe read back high");
  AST_FLAG_HI: assert property (rd_at(3'h4) |=> reg_rdata_q[7:2] == 6'h00)
    else $error("unused flag bits set");
  AST_CLR_WO: assert property (rd_at(3'h6) |=> reg_rdata_q == 8'h00)
    else $error("clear register readable");
  AST_CMP_GLOBAL: assert property (!global_irq_en [*2] |-> !cmp_irq_req_q)
    else $error("compare request without global enable");
  AST_OVF_GLOBAL: assert property (!global_irq_en [*2] |-> !ovf_irq_req_q)
    else $error("overflow request without global enable");
  AST_OE_ON: assert property (port_dir_out |=> compare_out_oe_q)
    else $error("pin driver off while direction out");
  AST_OE_OFF: assert property (!port_dir_out |=> !compare_out_oe_q)
    else $error("pin driver on while direction in");
  cover property (cmp_irq_req_q ##1 !cmp_irq_req_q);
endmodule // timer8_waveform_unit_assertions

bind timer8_waveform_unit timer8_waveform_unit_assertions chk_inst (
  .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .global_irq_en(global_irq_en),
  .cmp_irq_req_q(cmp_irq_req_q), .ovf_irq_req_q(ovf_irq_req_q),
  .port_dir_out(port_dir_out), .compare_out_oe_q(compare_out_oe_q));
`default_nettype wire

// ---- sim/timer8_pin_model.sv ----
// Pin-side model: external count source and compare pin monitor
`default_nettype none
module timer8_pin_model (
  // Clock
  input  wire logic mclk,
  // Pins
  input  wire logic compare_out_pin_q,
  output var  logic ext_count_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ext_count_pin = 1'b0;
  // Four cycles high and five low keeps well below half the sampling rate
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk) ext_count_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_count_pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  task automatic high_time(input int span, output int hi);
    hi = 0;
    repeat (span) begin
      @(posedge mclk);
      #1 hi += (compare_out_pin_q === 1'b1);
    end
  endtask
endmodule // timer8_pin_model
`default_nettype wire

// ---- sim/timer8_waveform_unit_tb_top.sv ----
// Self-checking bench for the 8-bit timer waveform unit
`default_nettype none
module timer8_waveform_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk, rst_b, reg_wr, reg_rd, global_irq_en, port_data;
  logic       cmp_vector_taken, ovf_vector_taken, port_dir_out;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, d;
  wire        cmp_irq_req_q, ovf_irq_req_q, irq_q, ext_count_pin;
  wire        compare_out_pin_q, compare_out_oe_q;
  int         miscompares = 0;
  int         checked = 0;
  timer8_waveform_unit timer8_waveform_unit_inst (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .global_irq_en(global_irq_en),
    .cmp_vector_taken(cmp_vector_taken),
    .ovf_vector_taken(ovf_vector_taken), .cmp_irq_req_q(cmp_irq_req_q),
    .ovf_irq_req_q(ovf_irq_req_q), .irq_q(irq_q),
    .ext_count_pin(ext_count_pin), .port_dir_out(port_dir_out),
    .port_data(port_data), .compare_out_pin_q(compare_out_pin_q),
    .compare_out_oe_q(compare_out_oe_q));
  timer8_pin_model timer8_pin_model_inst (.mclk(mclk),
    .compare_out_pin_q(compare_out_pin_q), .ext_count_pin(ext_count_pin));
  always #25 mclk = ~mclk;
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset_rw;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0]);
      chk("reset", d, 8'h00);
    end
    wr(3'h1, 8'h5A);
    rd(3'h1);
    chk("counter", d, 8'h5A);
    wr(3'h2, 8'h3C);
    rd(3'h2);
    chk("compare", d, 8'h3C);
    cyc(20);
    rd(3'h1);
    chk("stopped", d, 8'h5A);
  endtask
  task automatic t_overflow;
    wr(3'h2, 8'h80);
    wr(3'h1, 8'hFC);
    wr(3'h0, 8'h01);
    cyc(10);
    wr(3'h0, 8'h00);
    rd(3'h4);
    chk("ovf flag", d, 8'h01);
    wr(3'h4, 8'h00);
    rd(3'h4);
    chk("write zero", d, 8'h01);
    wr(3'h3, 8'h01);
    global_irq_en <= 1'b1;
    cyc(3);
    chk("ovf req", ovf_irq_req_q, 1'b1);
    ovf_vector_taken <= 1'b1;
    @(posedge mclk) ovf_vector_taken <= 1'b0;
    cyc(3);
    chk("ovf taken", ovf_irq_req_q, 1'b0);
    wr(3'h4, 8'h03);
    rd(3'h4);
    chk("write one", d, 8'h00);
  endtask
  task automatic t_prescale;
    int dv[5] = '{1, 8, 64, 256, 1024};
    for (int i = 0; i < 5; i++) begin
      wr(3'h1, 8'h00);
      wr(3'h0, i + 1);
      cyc(4 * dv[i]);
      wr(3'h0, 8'h00);
      rd(3'h1);
      chk("prescale", d >= 3 && d <= 6, 1'b1);
    end
  endtask
  task automatic t_extern;
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h07);
    timer8_pin_model_inst.pulses(5);
    cyc(6);
    wr(3'h0, 8'h06);
    timer8_pin_model_inst.pulses(3);
    cyc(6);
    wr(3'h0, 8'h00);
    rd(3'h1);
    chk("ext edges", d, 8'h08);
  endtask
  task automatic t_match;
    logic [7:0] start[2] = '{8'h10, 8'h0E};
    for (int i = 0; i < 2; i++) begin
      wr(3'h2, 8'h10);
      wr(3'h1, start[i]);
      wr(3'h4, 8'h03);
      wr(3'h0, 8'h01);
      cyc(5);
      wr(3'h0, 8'h00);
      rd(3'h4);
      chk("match", d, i ? 8'h02 : 8'h00);
    end
  endtask
  task automatic t_ctc_irq;
    int hi;
    wr(3'h2, 8'h04);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h03);
    wr(3'h3, 8'h02);
    wr(3'h7, 8'h02);
    wr(3'h0, 8'h19);
    timer8_pin_model_inst.high_time(100, hi);
    chk("ctc toggle", hi >= 45 && hi <= 55, 1'b1);
    wr(3'h0, 8'h08);
    cyc(3);
    chk("cmp req", cmp_irq_req_q, 1'b1);
    chk("irq", irq_q, 1'b1);
    rd(3'h4);
    chk("ctc flags", d, 8'h02);
    wr(3'h3, 8'h00);
    cyc(3);
    chk("masked", cmp_irq_req_q, 1'b0);
    cmp_vector_taken <= 1'b1;
    @(posedge mclk) cmp_vector_taken <= 1'b0;
    wr(3'h3, 8'h02);
    cyc(3);
    chk("cmp taken", cmp_irq_req_q, 1'b0);
    wr(3'h6, 8'h02);
    cyc(3);
    chk("irq clear", irq_q, 1'b0);
  endtask
  task automatic t_force;
    @(posedge mclk) port_data <= 1'b1;
    cyc(3);
    chk("port pass", compare_out_pin_q, 1'b1);
    port_dir_out <= 1'b0;
    cyc(2);
    chk("oe off", compare_out_oe_q, 1'b0);
    port_dir_out <= 1'b1;
    cyc(2);
    chk("oe on", compare_out_oe_q, 1'b1);
    wr(3'h4, 8'h03);
    wr(3'h0, 8'hB0);
    cyc(2);
    chk("force set", compare_out_pin_q, 1'b1);
    rd(3'h0);
    chk("force rd", d, 8'h30);
    rd(3'h4);
    chk("force flag", d, 8'h00);
    wr(3'h0, 8'hA0);
    cyc(2);
    chk("force clr", compare_out_pin_q, 1'b0);
  endtask
  task automatic t_pwm;
    logic [7:0] ct[5] = '{8'h69, 8'h79, 8'h69, 8'h61, 8'h71};
    logic [7:0] cp[5] = '{8'h40, 8'h40, 8'hFF, 8'h40, 8'h40};
    int lo[5] = '{124, 374, 510, 122, 376};
    int up[5] = '{136, 386, 510, 134, 388};
    int hi;
    for (int i = 0; i < 5; i++) begin
      wr(3'h0, 8'h00);
      wr(3'h2, cp[i]);
      wr(3'h1, 8'h00);
      wr(3'h0, ct[i]);
      cyc(300);
      timer8_pin_model_inst.high_time(510, hi);
      chk("pwm", hi >= lo[i] && hi <= up[i], 1'b1);
      wr(3'h4, 8'h03);
      cyc(520);
      rd(3'h4);
      chk("pwm ovf", d[0], 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    {reg_wr, reg_rd, global_irq_en, port_data} = 4'h0;
    {cmp_vector_taken, ovf_vector_taken, port_dir_out} = 3'h0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    cyc(16);
    rst_b <= 1'b1;
    port_dir_out <= 1'b1;
    t_reset_rw();
    t_overflow();
    t_prescale();
    t_extern();
    t_match();
    t_ctc_irq();
    t_force();
    t_pwm();
    final_report();
  end
  initial begin
    #1500000;
    miscompares++;
    final_report();
  end
endmodule // timer8_waveform_unit_tb_top
`default_nettype wire
